// File: shared/mnq_cfg.svh
// Register map, field positions and reset values of the master NI debug/QoS bank
`ifndef MNQ_CFG_SVH
`define MNQ_CFG_SVH

// ==========================================================
// Byte offsets
`define MNQ_OFS_IDENT_4_7    8'h18
`define MNQ_OFS_IDENT_8_11   8'h1C
`define MNQ_OFS_IDENT_12_15  8'h20
`define MNQ_OFS_NODE_FEAT    8'h24
`define MNQ_OFS_SILDBG       8'h28
`define MNQ_OFS_QOSACC       8'h2C
`define MNQ_OFS_RESP_SEL     8'h30
`define MNQ_OFS_SECR_ACC     8'h34

// ==========================================================
// Field positions
`define MNQ_SILDBG_CAP_BIT   31
`define MNQ_SILDBG_WR_LSB    20
`define MNQ_SILDBG_WR_MSB    28
`define MNQ_SILDBG_RD_LSB    8
`define MNQ_SILDBG_RD_MSB    16
`define MNQ_SILDBG_STALL_MSB 4
`define MNQ_STALL_AR         0
`define MNQ_STALL_R          1
`define MNQ_STALL_AW         2
`define MNQ_STALL_W          3
`define MNQ_STALL_B          4
`define MNQ_QOS_ARB_BIT      0
`define MNQ_QOS_STARV_BIT    1
`define MNQ_RESP_SEL_BIT     0
`define MNQ_SECR_ACC_BIT     0
`define MNQ_SECR_DBG_BIT     1
`define MNQ_BE_LOW           0
`define MNQ_BE_HIGH          3

// ==========================================================
// Reset values and codes
`define MNQ_RST_SECR         2'h0
`define MNQ_RST_QOS          2'h0
`define MNQ_RST_RESP_SEL     1'h0
`define MNQ_RST_CAP          1'h0
`define MNQ_RST_STALL        5'h00
`define MNQ_ZERO_WORD        32'h0000_0000
`define MNQ_AV_OKAY          2'h0
`define MNQ_AV_SLVERR        2'h2
`define MNQ_AV_DECERR        2'h3
`define MNQ_AXI_OKAY         2'h0
`define MNQ_AXI_SLVERR       2'h2

`endif

// File: shared/mnq_pkg.sv
// Types shared by the master NI debug/QoS register bank
package mnq_pkg;

  // ==========================================================
  // Register bank state
  typedef logic [31:0] mnq_word_t;
  typedef logic [1:0]  mnq_resp_t;

  typedef struct packed {
    logic      ack;
    mnq_word_t rdata;
    mnq_resp_t resp;
    logic [1:0] secr;
    logic       cap_en;
    logic [4:0] stall;
    logic [1:0] qos;
    logic       resp_sel;
  } mnq_regs_s;

endpackage : mnq_pkg

// File: src/mnq_outstanding_ctr.sv
// Outstanding transaction counter, request handshake to response
`timescale 1ns/1ps
`include "mnq_cfg.svh"

module mnq_outstanding_ctr #(
  parameter int WIDTH = 9
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_n,
  // Control
  input  wire logic             en,
  input  wire logic             inc,
  input  wire logic             dec,
  // Count
  output logic [WIDTH-1:0]      count_q
);

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
  } mnq_ctr_s;

  localparam logic [WIDTH-1:0] CNT_ZERO = '0;
  localparam logic [WIDTH-1:0] CNT_MAX  = '1;
  localparam logic [WIDTH-1:0] CNT_ONE  = {{(WIDTH-1){1'b0}}, 1'b1};

  mnq_ctr_s st_q;
  mnq_ctr_s st_d;

  // ==========================================================
  // Next count, saturating at both ends
  always_comb begin
    st_d = st_q;
    if (en) begin
      if (inc && !dec && st_q.cnt != CNT_MAX) begin
        st_d.cnt = st_q.cnt + CNT_ONE;
      end else if (dec && !inc && st_q.cnt != CNT_ZERO) begin
        st_d.cnt = st_q.cnt - CNT_ONE;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign count_q = st_q.cnt;

endmodule : mnq_outstanding_ctr

// File: src/mnq_regs.sv
// Master NI debug monitor, QoS accept and security register bank
`timescale 1ns/1ps
`include "mnq_cfg.svh"

module mnq_regs #(
  parameter int ADDR_W = 8,
  parameter int CNT_W  = 9
) (
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                rst_n,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0]   avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [3:0]          avs_byteenable,
  input  wire mnq_pkg::mnq_word_t  avs_writedata,
  input  wire logic                avs_nonsecure,
  output mnq_pkg::mnq_word_t       avs_readdata,
  output mnq_pkg::mnq_resp_t       avs_response,
  output logic                     avs_waitrequest,
  // Monitored AXI write channels
  input  wire logic                awvalid,
  input  wire logic                awready,
  input  wire logic                wvalid,
  input  wire logic                wready,
  input  wire logic                bvalid,
  input  wire logic                bready,
  // Monitored AXI read channels
  input  wire logic                arvalid,
  input  wire logic                arready,
  input  wire logic                rvalid,
  input  wire logic                rready,
  input  wire logic                rlast,
  // QoS accept controls
  output logic                     qos_arb_disable,
  output logic                     qos_starv_disable,
  // Cache maintenance response
  output mnq_pkg::mnq_resp_t       cmo_unsup_resp
);
  import mnq_pkg::*;

  mnq_regs_s st_q;
  mnq_regs_s st_d;

  logic [CNT_W-1:0] wr_cnt;
  logic [CNT_W-1:0] rd_cnt;
  logic [4:0]       ch_valid;
  logic [4:0]       ch_ready;
  logic [4:0]       stall_now;

  // ==========================================================
  // Channel stall detection
  assign ch_valid[`MNQ_STALL_AR] = arvalid;
  assign ch_ready[`MNQ_STALL_AR] = arready;
  assign ch_valid[`MNQ_STALL_R]  = rvalid;
  assign ch_ready[`MNQ_STALL_R]  = rready;
  assign ch_valid[`MNQ_STALL_AW] = awvalid;
  assign ch_ready[`MNQ_STALL_AW] = awready;
  assign ch_valid[`MNQ_STALL_W]  = wvalid;
  assign ch_ready[`MNQ_STALL_W]  = wready;
  assign ch_valid[`MNQ_STALL_B]  = bvalid;
  assign ch_ready[`MNQ_STALL_B]  = bready;

  genvar gi;
  generate
    for (gi = 0; gi <= `MNQ_SILDBG_STALL_MSB; gi++) begin : g_stall
      assign stall_now[gi] = ch_valid[gi] & ~ch_ready[gi];
    end
  endgenerate

  // ==========================================================
  // Outstanding counters
  mnq_outstanding_ctr #(
    .WIDTH (CNT_W)
  ) u_wr_ctr (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .en      (st_q.cap_en),
    .inc     (awvalid & awready),
    .dec     (bvalid & bready),
    .count_q (wr_cnt)
  );

  mnq_outstanding_ctr #(
    .WIDTH (CNT_W)
  ) u_rd_ctr (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .en      (st_q.cap_en),
    .inc     (arvalid & arready),
    .dec     (rvalid & rready & rlast),
    .count_q (rd_cnt)
  );

  // ==========================================================
  // Access decode and next state
  logic            req;
  logic            hit;
  logic            allow;
  logic            do_wr;
  logic            be_lo;
  logic            be_hi;
  logic [ADDR_W-1:0] ofs_i47;
  logic [ADDR_W-1:0] ofs_i811;
  logic [ADDR_W-1:0] ofs_i1215;
  logic [ADDR_W-1:0] ofs_feat;
  logic [ADDR_W-1:0] ofs_dbg;
  logic [ADDR_W-1:0] ofs_qos;
  logic [ADDR_W-1:0] ofs_rsel;
  logic [ADDR_W-1:0] ofs_secr;
  mnq_word_t       rd_word;
  mnq_word_t       mon_word;
  logic            wr_qos;
  logic            wr_rsel;
  logic            wr_secr;
  logic            wr_cap;

  assign ofs_i47   = ADDR_W'(`MNQ_OFS_IDENT_4_7);
  assign ofs_i811  = ADDR_W'(`MNQ_OFS_IDENT_8_11);
  assign ofs_i1215 = ADDR_W'(`MNQ_OFS_IDENT_12_15);
  assign ofs_feat  = ADDR_W'(`MNQ_OFS_NODE_FEAT);
  assign ofs_dbg   = ADDR_W'(`MNQ_OFS_SILDBG);
  assign ofs_qos   = ADDR_W'(`MNQ_OFS_QOSACC);
  assign ofs_rsel  = ADDR_W'(`MNQ_OFS_RESP_SEL);
  assign ofs_secr  = ADDR_W'(`MNQ_OFS_SECR_ACC);

  assign req   = avs_read | avs_write;
  assign be_lo = avs_byteenable[`MNQ_BE_LOW];
  assign be_hi = avs_byteenable[`MNQ_BE_HIGH];

  // ==========================================================
  // Word hit and security permission
  always_comb begin
    hit   = 1'b1;
    allow = 1'b1;
    case (avs_address)
      ofs_i47: begin
        allow = 1'b1;
      end
      ofs_i811: begin
        allow = 1'b1;
      end
      ofs_i1215: begin
        allow = 1'b1;
      end
      ofs_feat: begin
        allow = ~avs_nonsecure | st_q.secr[`MNQ_SECR_ACC_BIT];
      end
      ofs_dbg: begin
        allow = ~avs_nonsecure | st_q.secr[`MNQ_SECR_ACC_BIT]
              | st_q.secr[`MNQ_SECR_DBG_BIT];
      end
      ofs_qos: begin
        allow = ~avs_nonsecure | st_q.secr[`MNQ_SECR_ACC_BIT];
      end
      ofs_rsel: begin
        allow = ~avs_nonsecure | st_q.secr[`MNQ_SECR_ACC_BIT];
      end
      ofs_secr: begin
        allow = ~avs_nonsecure;
      end
      default: begin
        hit   = 1'b0;
        allow = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Monitor word assembly
  always_comb begin
    mon_word = `MNQ_ZERO_WORD;
    mon_word[`MNQ_SILDBG_CAP_BIT] = st_q.cap_en;
    mon_word[`MNQ_SILDBG_WR_MSB:`MNQ_SILDBG_WR_LSB] = wr_cnt;
    mon_word[`MNQ_SILDBG_RD_MSB:`MNQ_SILDBG_RD_LSB] = rd_cnt;
    mon_word[`MNQ_SILDBG_STALL_MSB:0] = st_q.stall;
  end

  // ==========================================================
  // Read data per word
  always_comb begin
    rd_word = `MNQ_ZERO_WORD;
    case (avs_address)
      ofs_i47: begin
        rd_word = `MNQ_ZERO_WORD;
      end
      ofs_i811: begin
        rd_word = `MNQ_ZERO_WORD;
      end
      ofs_i1215: begin
        rd_word = `MNQ_ZERO_WORD;
      end
      ofs_feat: begin
        rd_word = `MNQ_ZERO_WORD;
      end
      ofs_dbg: begin
        rd_word = mon_word;
      end
      ofs_qos: begin
        rd_word[`MNQ_QOS_STARV_BIT:0] = st_q.qos;
      end
      ofs_rsel: begin
        rd_word[`MNQ_RESP_SEL_BIT] = st_q.resp_sel;
      end
      ofs_secr: begin
        rd_word[`MNQ_SECR_DBG_BIT:0] = st_q.secr;
      end
      default: begin
        rd_word = `MNQ_ZERO_WORD;
      end
    endcase
  end

  // ==========================================================
  // Write strobes, committed at the answer edge
  assign do_wr   = avs_write & st_q.ack & hit & allow;
  assign wr_qos  = do_wr & be_lo & (avs_address == ofs_qos);
  assign wr_rsel = do_wr & be_lo & (avs_address == ofs_rsel);
  assign wr_secr = do_wr & be_lo & (avs_address == ofs_secr);
  assign wr_cap  = do_wr & be_hi & (avs_address == ofs_dbg);

  // ==========================================================
  // Next state
  always_comb begin
    st_d = st_q;

    // One wait state, then answer
    st_d.ack = req & ~st_q.ack;
    if (req && !st_q.ack) begin
      if (!hit) begin
        st_d.rdata = `MNQ_ZERO_WORD;
        st_d.resp  = `MNQ_AV_DECERR;
      end else if (!allow) begin
        st_d.rdata = `MNQ_ZERO_WORD;
        st_d.resp  = `MNQ_AV_SLVERR;
      end else begin
        st_d.rdata = avs_read ? rd_word : `MNQ_ZERO_WORD;
        st_d.resp  = `MNQ_AV_OKAY;
      end
    end

    // Writes land at the answer edge
    if (wr_qos) begin
      st_d.qos = avs_writedata[`MNQ_QOS_STARV_BIT:`MNQ_QOS_ARB_BIT];
    end
    if (wr_rsel) begin
      st_d.resp_sel = avs_writedata[`MNQ_RESP_SEL_BIT];
    end
    if (wr_secr) begin
      st_d.secr = avs_writedata[`MNQ_SECR_DBG_BIT:`MNQ_SECR_ACC_BIT];
    end
    if (wr_cap) begin
      st_d.cap_en = avs_writedata[`MNQ_SILDBG_CAP_BIT];
    end

    // Live channel sampling while capturing
    if (st_q.cap_en) begin
      st_d.stall = stall_now;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q.ack      <= 1'b0;
      st_q.rdata    <= `MNQ_ZERO_WORD;
      st_q.resp     <= `MNQ_AV_OKAY;
      st_q.secr     <= `MNQ_RST_SECR;
      st_q.cap_en   <= `MNQ_RST_CAP;
      st_q.stall    <= `MNQ_RST_STALL;
      st_q.qos      <= `MNQ_RST_QOS;
      st_q.resp_sel <= `MNQ_RST_RESP_SEL;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // Outputs
  assign avs_waitrequest   = req & ~st_q.ack;
  assign avs_readdata      = st_q.rdata;
  assign avs_response      = st_q.resp;
  assign qos_arb_disable   = st_q.qos[`MNQ_QOS_ARB_BIT];
  assign qos_starv_disable = st_q.qos[`MNQ_QOS_STARV_BIT];
  assign cmo_unsup_resp    = st_q.resp_sel ? `MNQ_AXI_SLVERR : `MNQ_AXI_OKAY;

endmodule : mnq_regs

// File: test/mnq_axi_slave.sv
// Downstream AXI slave model on the monitored link
`timescale 1ns/1ps
module mnq_axi_slave (
  // Clock, reset and pacing
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic stall,
  // Link
  input wire logic awvalid,
  input wire logic wvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic rready,
  output logic     awready,
  output logic     wready,
  output logic     bvalid,
  output logic     arready,
  output logic     rvalid,
  output logic     rlast
);
  assign awready = !stall;
  assign wready  = !stall;
  assign arready = !stall;
  assign rlast   = rvalid;
  // Single-beat responses after each request
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid <= 1'b0;
      rvalid <= 1'b0;
    end else begin
      if (awvalid && awready && wvalid && wready) bvalid <= 1'b1;
      else if (bready) bvalid <= 1'b0;
      if (arvalid && arready) rvalid <= 1'b1;
      else if (rready) rvalid <= 1'b0;
    end
  end
endmodule : mnq_axi_slave

// File: test/mnq_regs_monitor.sv
// Port checker for the master NI register bank
`timescale 1ns/1ps
module mnq_regs_chk
  import mnq_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic              mclk,
  input wire logic              rst_n,
  // Register bus
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [3:0]        avs_byteenable,
  input wire mnq_word_t         avs_writedata,
  input wire logic              avs_nonsecure,
  input wire mnq_word_t         avs_readdata,
  input wire mnq_resp_t         avs_response,
  input wire logic              avs_waitrequest,
  // Controls
  input wire logic              qos_arb_disable,
  input wire logic              qos_starv_disable,
  input wire mnq_resp_t         cmo_unsup_resp
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Answered access and accepted Secure write
  sequence s_ans(logic [ADDR_W-1:0] a);
    (avs_read || avs_write) && !avs_waitrequest && avs_address == a;
  endsequence
  sequence s_wr(logic [ADDR_W-1:0] a);
    s_ans(a) ##0 avs_write && !avs_nonsecure && avs_response == 2'h0 && avs_byteenable[0];
  endsequence
  // ==========================================================
  // Checks
  AST_IDENT_8_11: assert property (
    s_ans(8'h1C) ##0 avs_read |-> avs_readdata == 32'h0 && avs_response == 2'h0)
    else $error("ident word 8-11 not zero");
  AST_IDENT_12_15: assert property (
    s_ans(8'h20) ##0 avs_read |-> avs_readdata == 32'h0 && avs_response == 2'h0)
    else $error("ident word 12-15 not zero");
  AST_FEAT_ZERO: assert property (
    s_ans(8'h24) ##0 avs_read |-> avs_readdata == 32'h0)
    else $error("feature word not zero");
  AST_OVR_NS: assert property (
    s_ans(8'h34) ##0 avs_nonsecure |-> avs_response == 2'h2)
    else $error("override word open to nonsecure");
  AST_QOS_ARB: assert property (
    s_wr(8'h2C) |=> qos_arb_disable == $past(avs_writedata[0]))
    else $error("arbitration disable wrong");
  AST_QOS_STARV: assert property (
    s_wr(8'h2C) |=> qos_starv_disable == $past(avs_writedata[1]))
    else $error("starvation disable wrong");
  AST_CMO_SEL: assert property (
    s_wr(8'h30) |=> cmo_unsup_resp == ($past(avs_writedata[0]) ? 2'h2 : 2'h0))
    else $error("maintenance response wrong");
  AST_QOS_HOLD: assert property (
    $changed({qos_arb_disable, qos_starv_disable})
    |-> $past(avs_write && !avs_waitrequest && avs_address == 8'h2C))
    else $error("qos control moved without write");
  AST_CMO_HOLD: assert property (
    $changed(cmo_unsup_resp) |-> $past(avs_write && !avs_waitrequest && avs_address == 8'h30))
    else $error("maintenance response moved without write");
endmodule : mnq_regs_chk

bind mnq_regs mnq_regs_chk #(.ADDR_W(ADDR_W)) u_chk (.mclk, .rst_n, .avs_address, .avs_read,
  .avs_write, .avs_byteenable, .avs_writedata, .avs_nonsecure, .avs_readdata, .avs_response,
  .avs_waitrequest, .qos_arb_disable, .qos_starv_disable, .cmo_unsup_resp);

// File: test/testbench.sv
// Self-checking bench for the master NI register bank
`timescale 1ns/1ps
module testbench;
  import mnq_pkg::*;
  logic mclk = 1'b0, rst_n = 1'b0, stall = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0, avs_write = 1'b0, avs_nonsecure = 1'b0, avs_waitrequest;
  logic [3:0] avs_byteenable = 4'h0;
  mnq_word_t avs_writedata = 32'h0, avs_readdata;
  mnq_resp_t avs_response, cmo_unsup_resp;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, rlast, qos_arb_disable, qos_starv_disable;
  int bad_count = 0, checked = 0, cycles = 0;
  logic [7:0] idw [4] = '{8'h18, 8'h1C, 8'h20, 8'h24};
  logic [1:0] qv [3] = '{2'h0, 2'h1, 2'h3};

  always #20 mclk = ~mclk;
  mnq_axi_slave u_slv (.mclk, .rst_n, .stall, .awvalid, .wvalid, .bready, .arvalid, .rready,
    .awready, .wready, .bvalid, .arready, .rvalid, .rlast);
  mnq_regs dut (.mclk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_byteenable,
    .avs_writedata, .avs_nonsecure, .avs_readdata, .avs_response, .avs_waitrequest,
    .awvalid, .awready, .wvalid, .wready, .bvalid, .bready, .arvalid, .arready, .rvalid,
    .rready, .rlast, .qos_arb_disable, .qos_starv_disable, .cmo_unsup_resp);

  // ==========================================================
  // Shared tasks
  task automatic summarize();
    if (bad_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [7:0] a, input mnq_word_t d,
      input logic [3:0] be, input logic ns, output mnq_word_t rd, output mnq_resp_t rs);
    @(posedge mclk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_nonsecure <= ns;
    // Settled answer seen mid-cycle, taken and released at the next rising edge
    @(negedge mclk);
    while (avs_waitrequest !== 1'b0) @(negedge mclk);
    rd = avs_readdata;
    rs = avs_response;
    @(posedge mclk);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(negedge mclk);
  endtask : acc
  task automatic xr(input logic [7:0] a, input logic ns, input mnq_word_t ed, input mnq_resp_t er);
    mnq_word_t rd;
    mnq_resp_t rs;
    acc(1'b0, a, 32'h0, 4'hF, ns, rd, rs);
    chk("readdata", rd, ed);
    chk("read response", {30'h0, rs}, {30'h0, er});
  endtask : xr
  task automatic xw(input logic [7:0] a, input mnq_word_t d, input logic [3:0] be,
      input logic ns, input mnq_resp_t er);
    mnq_word_t rd;
    mnq_resp_t rs;
    acc(1'b1, a, d, be, ns, rd, rs);
    chk("write response", {30'h0, rs}, {30'h0, er});
  endtask : xw

  // ==========================================================
  // Scenarios
  task automatic t_ident();
    chk("reset controls", {qos_starv_disable, qos_arb_disable, cmo_unsup_resp}, 32'h0);
    xr(8'h28, 1'b0, 32'h0, 2'h0);
    foreach (idw[i]) xr(idw[i], 1'b1, 32'h0, idw[i] == 8'h24 ? 2'h2 : 2'h0);
    xw(8'h24, 32'hFFFF_FFFF, 4'hF, 1'b0, 2'h0);
    xr(8'h24, 1'b0, 32'h0, 2'h0);
    xr(8'h40, 1'b0, 32'h0, 2'h3);
  endtask : t_ident
  task automatic t_secure();
    xr(8'h28, 1'b1, 32'h0, 2'h2);
    xw(8'h34, 32'h3, 4'hF, 1'b1, 2'h2);
    xw(8'h34, 32'h2, 4'hF, 1'b0, 2'h0);
    xr(8'h34, 1'b0, 32'h2, 2'h0);
    xr(8'h28, 1'b1, 32'h0, 2'h0);
    xw(8'h2C, 32'h3, 4'hF, 1'b1, 2'h2);
    chk("qos after refusal", {qos_starv_disable, qos_arb_disable}, 32'h0);
    xw(8'h34, 32'h1, 4'hF, 1'b0, 2'h0);
    xr(8'h28, 1'b1, 32'h0, 2'h0);
    xw(8'h2C, 32'h3, 4'hF, 1'b1, 2'h0);
    chk("qos by nonsecure", {qos_starv_disable, qos_arb_disable}, 32'h3);
    xw(8'h34, 32'h0, 4'hF, 1'b0, 2'h0);
    xr(8'h30, 1'b1, 32'h0, 2'h2);
  endtask : t_secure
  task automatic t_qos();
    foreach (qv[i]) begin
      xw(8'h2C, {30'h0, qv[i]}, 4'hF, 1'b0, 2'h0);
      chk("qos outputs", {qos_starv_disable, qos_arb_disable}, qv[i]);
      xr(8'h2C, 1'b0, {30'h0, qv[i]}, 2'h0);
    end
    xw(8'h30, 32'h1, 4'hF, 1'b0, 2'h0);
    chk("slverr select", cmo_unsup_resp, 32'h2);
    xr(8'h30, 1'b0, 32'h1, 2'h0);
    xw(8'h30, 32'h0, 4'hE, 1'b0, 2'h0);
    chk("masked lane", cmo_unsup_resp, 32'h2);
    xw(8'h30, 32'h0, 4'hF, 1'b0, 2'h0);
    chk("okay select", cmo_unsup_resp, 32'h0);
  endtask : t_qos
  task automatic t_mon();
    xw(8'h28, 32'h8000_0000, 4'hF, 1'b0, 2'h0);
    @(posedge mclk);
    stall <= 1'b1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    arvalid <= 1'b1;
    repeat (2) @(posedge mclk);
    xr(8'h28, 1'b0, 32'h8000_000D, 2'h0);
    @(posedge mclk);
    stall <= 1'b0;
    @(posedge mclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    arvalid <= 1'b0;
    repeat (2) @(posedge mclk);
    xr(8'h28, 1'b0, 32'h8010_0112, 2'h0);
    @(posedge mclk);
    bready <= 1'b1;
    rready <= 1'b1;
    repeat (2) @(posedge mclk);
    xr(8'h28, 1'b0, 32'h8000_0000, 2'h0);
    xw(8'h28, 32'h0, 4'hF, 1'b0, 2'h0);
    @(posedge mclk);
    stall <= 1'b1;
    arvalid <= 1'b1;
    repeat (2) @(posedge mclk);
    xr(8'h28, 1'b0, 32'h0, 2'h0);
    @(posedge mclk);
    stall <= 1'b0;
    arvalid <= 1'b0;
  endtask : t_mon

  // ==========================================================
  // Main sequence and hang guard
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      summarize();
    end
  end
  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    t_ident();
    t_secure();
    t_qos();
    t_mon();
    summarize();
  end
endmodule : testbench
